// ### dp_exc_params.svh
// Purpose: Offsets, field positions and reset values for the
//          double-precision exception map.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef DP_EXC_PARAMS_SVH
`define DP_EXC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DP_EXC_CTRL_OFS    8'h00
`define DP_EXC_LAST_OFS    8'h04
`define DP_EXC_STICKY_OFS  8'h08
`define DP_EXC_COUNT_OFS   8'h0c
`define DP_EXC_QUERY_OFS   8'h10
`define DP_EXC_STRAY_OFS   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DP_EXC_CTRL_EN_BIT   0
`define DP_EXC_LAST_CLS_LSB  8
`define DP_EXC_LAST_PK_BIT   16
`define DP_EXC_LAST_VLD_BIT  31
`define DP_EXC_QUERY_MSK_LSB 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DP_EXC_CTRL_RST    1'b1
`define DP_EXC_FLAGS_RST   6'h00
`define DP_EXC_COUNT_RST   32'h0000_0000
`define DP_EXC_QUERY_RST   4'h0

`endif

// ### dp_exc_pkg.sv
// Purpose: Types shared by the exception map files.
// Assumes: Six exception conditions, invalid in bit 0.
// Notes:   Class codes are decoder-facing and fixed.
package dp_exc_pkg;

    typedef struct packed {
        logic precision;
        logic underflow;
        logic overflow;
        logic divide_by_zero;
        logic denormal;
        logic invalid;
    } exc_flags_s;

    typedef enum logic [3:0] {
        cls_add_sub        = 4'h0,
        cls_mul            = 4'h1,
        cls_div            = 4'h2,
        cls_cmp_predicate  = 4'h3,
        cls_cmp_flags      = 4'h4,
        cls_max_min        = 4'h5,
        cls_root           = 4'h6,
        cls_to_int_rounded = 4'h7,
        cls_to_int_trunc   = 4'h8,
        cls_int_to_sp      = 4'h9,
        cls_int_to_dp      = 4'ha,
        cls_dp_to_sp       = 4'hb,
        cls_sp_to_dp       = 4'hc,
        cls_bitwise        = 4'hd,
        cls_move           = 4'he,
        cls_shuffle        = 4'hf
    } op_class_e;

    typedef struct packed {
        op_class_e op_class;
        logic packed_op;
    } op_req_s;

endpackage

// ### exc_class_map.sv
// Purpose: Maps an operation class to the exceptions it may raise.
// Assumes: Purely combinational; one class per call.
// Notes:   Every class code is legal, so no default arm.
`timescale 1ns/1ps
`default_nettype none

module exc_class_map
(
    input wire dp_exc_pkg::op_class_e op_class,
    output dp_exc_pkg::exc_flags_s allowed
);

    always_comb
    begin
        allowed = '0;
        unique case (op_class)
            dp_exc_pkg::cls_add_sub:
                allowed = 6'b111011;
            dp_exc_pkg::cls_mul:
                allowed = 6'b111011;
            dp_exc_pkg::cls_div:
                allowed = 6'b111111;
            dp_exc_pkg::cls_cmp_predicate:
                allowed = 6'b000011;
            dp_exc_pkg::cls_cmp_flags:
                allowed = 6'b000011;
            dp_exc_pkg::cls_max_min:
                allowed = 6'b000011;
            dp_exc_pkg::cls_root:
                allowed = 6'b100011;
            dp_exc_pkg::cls_to_int_rounded:
                allowed = 6'b100001;
            dp_exc_pkg::cls_to_int_trunc:
                allowed = 6'b100001;
            dp_exc_pkg::cls_int_to_sp:
                allowed = 6'b100000;
            dp_exc_pkg::cls_int_to_dp:
                allowed = 6'b000000;
            dp_exc_pkg::cls_dp_to_sp:
                allowed = 6'b111011;
            dp_exc_pkg::cls_sp_to_dp:
                allowed = 6'b000011;
            dp_exc_pkg::cls_bitwise:
                allowed = 6'b000000;
            dp_exc_pkg::cls_move:
                allowed = 6'b000000;
            dp_exc_pkg::cls_shuffle:
                allowed = 6'b000000;
        endcase
    end

endmodule // exc_class_map

`default_nettype wire

// ### lane_flag_merge.sv
// Purpose: Merges per-lane exception detections into one vector.
// Assumes: Lane flags come from logic on the same clock.
// Notes:   Inactive lanes are ignored.
`timescale 1ns/1ps
`default_nettype none

module lane_flag_merge
#(
    parameter int LANES = 2
)
(
    input wire dp_exc_pkg::exc_flags_s [LANES-1:0] lane_flags,
    input wire logic [LANES-1:0] lane_active,
    output dp_exc_pkg::exc_flags_s merged
);

    always_comb
    begin
        merged = '0;
        for (int i = 0; i < LANES; i++)
        begin
            if (lane_active[i])
            begin
                merged = merged | lane_flags[i];
            end
        end
    end

endmodule // lane_flag_merge

`default_nettype wire

// ### dp_simd_fp_exception_map.sv
// Purpose: Gates the datapath's exception detections by the set of
//          conditions that the decoded operation class may raise.
// Assumes: Decoder and datapath run on pclk; no input synchroniser.
// Notes:   One result per accepted operation, one cycle later.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dp_exc_params.svh"

module dp_simd_fp_exception_map
#(
    parameter int LANES = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire dp_exc_pkg::op_req_s op_req,
    input wire dp_exc_pkg::exc_flags_s [LANES-1:0] lane_flags,
    output logic exc_valid,
    output dp_exc_pkg::exc_flags_s exc_flags,
    output dp_exc_pkg::exc_flags_s exc_allowed,
    output logic exc_stray
);

    // ------------------------------------------------------------
    // Class lookup and lane merge
    // ------------------------------------------------------------
    dp_exc_pkg::exc_flags_s allowed;
    dp_exc_pkg::exc_flags_s merged;
    dp_exc_pkg::exc_flags_s query_mask;
    logic [LANES-1:0] lane_active;
    logic [3:0] query_reg;
    logic [3:0] query_next;

    exc_class_map u_map
    (
        .op_class (op_req.op_class),
        .allowed  (allowed)
    );

    // A second lookup lets software read the table without having
    // to stall the decoder's port.
    exc_class_map u_query_map
    (
        .op_class (dp_exc_pkg::op_class_e'(query_reg)),
        .allowed  (query_mask)
    );

    // Scalar forms only compute in the low lane; upper lanes carry
    // passed-through data whose flags must not leak out.
    always_comb
    begin
        lane_active = '1;
        if (!op_req.packed_op)
        begin
            lane_active = {{(LANES-1){1'b0}}, 1'b1};
        end
    end

    lane_flag_merge #(.LANES(LANES)) u_merge
    (
        .lane_flags  (lane_flags),
        .lane_active (lane_active),
        .merged      (merged)
    );

    // ------------------------------------------------------------
    // Result pipeline
    // ------------------------------------------------------------
    logic ctrl_en_reg;
    logic ctrl_en_next;
    logic exc_valid_reg;
    logic exc_valid_next;
    dp_exc_pkg::exc_flags_s flags_reg;
    dp_exc_pkg::exc_flags_s flags_next;
    dp_exc_pkg::exc_flags_s allowed_reg;
    dp_exc_pkg::exc_flags_s allowed_next;
    logic stray_reg;
    logic stray_next;
    dp_exc_pkg::exc_flags_s gated;
    dp_exc_pkg::exc_flags_s stray_bits;

    always_comb
    begin
        gated = merged & allowed;
        stray_bits = merged & ~allowed;
        if (!ctrl_en_reg)
        begin
            gated = merged;
            stray_bits = '0;
        end
    end

    always_comb
    begin
        exc_valid_next = op_valid;
        flags_next = flags_reg;
        allowed_next = allowed_reg;
        stray_next = 1'b0;
        if (op_valid)
        begin
            flags_next = gated;
            allowed_next = allowed;
            stray_next = |stray_bits;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc_valid_reg <= 1'b0;
            flags_reg <= `DP_EXC_FLAGS_RST;
            allowed_reg <= `DP_EXC_FLAGS_RST;
            stray_reg <= 1'b0;
        end
        else
        begin
            exc_valid_reg <= exc_valid_next;
            flags_reg <= flags_next;
            allowed_reg <= allowed_next;
            stray_reg <= stray_next;
        end
    end

    assign exc_valid = exc_valid_reg;
    assign exc_flags = flags_reg;
    assign exc_allowed = allowed_reg;
    assign exc_stray = stray_reg;

    // ------------------------------------------------------------
    // Software-visible history
    // ------------------------------------------------------------
    logic [3:0] last_cls_reg;
    logic [3:0] last_cls_next;
    logic last_pk_reg;
    logic last_pk_next;
    logic last_vld_reg;
    logic last_vld_next;
    dp_exc_pkg::exc_flags_s sticky_reg;
    dp_exc_pkg::exc_flags_s sticky_next;
    dp_exc_pkg::exc_flags_s stray_sticky_reg;
    dp_exc_pkg::exc_flags_s stray_sticky_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic wr_access;
    logic rd_setup;
    logic addr_hit;
    logic [31:0] rd_value;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    assign wr_access = psel && penable && pwrite && addr_hit;
    assign rd_setup = psel && !penable && !pwrite;

    // A clear that meets a new event in the same cycle loses: the
    // event's bit stays set so nothing is dropped.
    always_comb
    begin
        ctrl_en_next = ctrl_en_reg;
        query_next = query_reg;
        sticky_next = sticky_reg;
        stray_sticky_next = stray_sticky_reg;
        count_next = count_reg;
        last_cls_next = last_cls_reg;
        last_pk_next = last_pk_reg;
        last_vld_next = last_vld_reg;
        if (wr_access)
        begin
            unique case (paddr)
                `DP_EXC_CTRL_OFS:
                    ctrl_en_next = pwdata[`DP_EXC_CTRL_EN_BIT];
                `DP_EXC_STICKY_OFS:
                    sticky_next = sticky_reg & ~pwdata[5:0];
                `DP_EXC_COUNT_OFS:
                    count_next = `DP_EXC_COUNT_RST;
                `DP_EXC_QUERY_OFS:
                    query_next = pwdata[3:0];
                `DP_EXC_STRAY_OFS:
                    stray_sticky_next = stray_sticky_reg & ~pwdata[5:0];
                default:
                    ;
            endcase
        end
        if (op_valid)
        begin
            sticky_next = sticky_next | gated;
            stray_sticky_next = stray_sticky_next | stray_bits;
            last_cls_next = op_req.op_class;
            last_pk_next = op_req.packed_op;
            last_vld_next = 1'b1;
            if (|gated)
            begin
                count_next = count_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_en_reg <= `DP_EXC_CTRL_RST;
            query_reg <= `DP_EXC_QUERY_RST;
            sticky_reg <= `DP_EXC_FLAGS_RST;
            stray_sticky_reg <= `DP_EXC_FLAGS_RST;
            count_reg <= `DP_EXC_COUNT_RST;
            last_cls_reg <= 4'h0;
            last_pk_reg <= 1'b0;
            last_vld_reg <= 1'b0;
        end
        else
        begin
            ctrl_en_reg <= ctrl_en_next;
            query_reg <= query_next;
            sticky_reg <= sticky_next;
            stray_sticky_reg <= stray_sticky_next;
            count_reg <= count_next;
            last_cls_reg <= last_cls_next;
            last_pk_reg <= last_pk_next;
            last_vld_reg <= last_vld_next;
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    always_comb
    begin
        addr_hit = 1'b1;
        rd_value = 32'h0000_0000;
        unique case (paddr)
            `DP_EXC_CTRL_OFS:
                rd_value[`DP_EXC_CTRL_EN_BIT] = ctrl_en_reg;
            `DP_EXC_LAST_OFS:
            begin
                rd_value[5:0] = flags_reg;
                rd_value[`DP_EXC_LAST_CLS_LSB +: 4] = last_cls_reg;
                rd_value[`DP_EXC_LAST_PK_BIT] = last_pk_reg;
                rd_value[`DP_EXC_LAST_VLD_BIT] = last_vld_reg;
            end
            `DP_EXC_STICKY_OFS:
                rd_value[5:0] = sticky_reg;
            `DP_EXC_COUNT_OFS:
                rd_value = count_reg;
            `DP_EXC_QUERY_OFS:
            begin
                rd_value[3:0] = query_reg;
                rd_value[`DP_EXC_QUERY_MSK_LSB +: 6] = query_mask;
            end
            `DP_EXC_STRAY_OFS:
                rd_value[5:0] = stray_sticky_reg;
            default:
                addr_hit = 1'b0;
        endcase
    end

    // Read data is captured in the setup phase, so the access phase
    // completes at once with no wait states.
    always_comb
    begin
        prdata_next = prdata_reg;
        if (rd_setup)
        begin
            prdata_next = rd_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

endmodule // dp_simd_fp_exception_map

`default_nettype wire

// ### exc_map_checker_monitor.sv
// Purpose: Checks timing, lane merge and class masks of the map.
// Assumes: Enable is tracked from the bus writes to the control word.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module exc_map_checker
#(
    parameter int LANES = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic op_valid,
    input wire dp_exc_pkg::op_req_s op_req,
    input wire dp_exc_pkg::exc_flags_s [LANES-1:0] lane_flags,
    input wire logic exc_valid,
    input wire dp_exc_pkg::exc_flags_s exc_flags,
    input wire dp_exc_pkg::exc_flags_s exc_allowed,
    input wire logic exc_stray
);
    logic [5:0] sel;
    logic [5:0] sel_d;
    logic took;
    logic en;
    logic en_d;
    dp_exc_pkg::op_class_e cls;

    always_comb
    begin
        sel = lane_flags[0];
        for (int i = 1; i < LANES; i++)
        begin
            sel = sel | (op_req.packed_op ? lane_flags[i] : 6'h00);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            took <= 1'b0;
            en <= 1'b1;
            en_d <= 1'b1;
            sel_d <= 6'h00;
            cls <= dp_exc_pkg::cls_add_sub;
        end
        else
        begin
            // The gate seen by an op is the enable before this edge.
            en_d <= en;
            if (psel && penable && pwrite && paddr == 8'h00)
            begin
                en <= pwdata[0];
            end
            took <= op_valid;
            sel_d <= sel;
            cls <= op_req.op_class;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PULSE: assert property (exc_valid == took)
        else $error("result pulse misplaced");
    AST_MERGE: assert property (
        took |-> exc_flags == (en_d ? (sel_d & exc_allowed) : sel_d))
        else $error("merged flags wrong");
    AST_STRAY: assert property (
        took |-> exc_stray == (en_d && |(sel_d & ~exc_allowed)))
        else $error("stray flag wrong");
    AST_HOLD: assert property (
        !took |-> $stable(exc_flags) && !exc_stray)
        else $error("flags moved without op");
    AST_ADD: assert property (
        took && cls == dp_exc_pkg::cls_add_sub
        |-> exc_allowed == 6'h3b) else $error("add mask");
    AST_DIV: assert property (
        took && cls == dp_exc_pkg::cls_div
        |-> exc_allowed == 6'h3f) else $error("div mask");
    AST_CMP: assert property (
        took && cls == dp_exc_pkg::cls_cmp_predicate
        |-> exc_allowed == 6'h03) else $error("compare mask");
    AST_ROOT: assert property (
        took && cls == dp_exc_pkg::cls_root
        |-> exc_allowed == 6'h23) else $error("root mask");
    AST_TRUNC: assert property (
        took && cls == dp_exc_pkg::cls_to_int_trunc
        |-> exc_allowed == 6'h21) else $error("trunc mask");
    AST_ITOS: assert property (
        took && cls == dp_exc_pkg::cls_int_to_sp
        |-> exc_allowed == 6'h20) else $error("int to sp mask");
    AST_ITOD: assert property (
        took && en_d && cls == dp_exc_pkg::cls_int_to_dp
        |-> exc_flags == 6'h00) else $error("int to dp flags");
    AST_BITS: assert property (
        took && en_d && cls == dp_exc_pkg::cls_bitwise
        |-> exc_flags == 6'h00) else $error("bitwise flags");
endmodule // exc_map_checker

bind dp_simd_fp_exception_map exc_map_checker #(.LANES(LANES)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .op_valid(op_valid), .op_req(op_req),
    .lane_flags(lane_flags), .exc_valid(exc_valid), .exc_flags(exc_flags),
    .exc_allowed(exc_allowed), .exc_stray(exc_stray)
);
`default_nettype wire

// ### fp_datapath_model.sv
// Purpose: Stand-in for the decoder and datapath feeding the map.
// Assumes: One operation per issue pulse, launched on the next edge.
// Notes:   Between ops the lines toggle, so a stale sample shows.
`timescale 1ns/1ps
`default_nettype none

module fp_datapath_model
#(
    parameter int LANES = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic issue,
    input wire dp_exc_pkg::op_req_s req,
    input wire dp_exc_pkg::exc_flags_s [LANES-1:0] det,
    output logic op_valid,
    output dp_exc_pkg::op_req_s op_req,
    output dp_exc_pkg::exc_flags_s [LANES-1:0] lane_flags
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_valid <= 1'b0;
            op_req <= '0;
            lane_flags <= '0;
        end
        else if (issue)
        begin
            op_valid <= 1'b1;
            op_req <= req;
            lane_flags <= det;
        end
        else
        begin
            op_valid <= 1'b0;
            op_req <= ~op_req;
            lane_flags <= ~lane_flags;
        end
    end
endmodule // fp_datapath_model
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the exception map.
// Assumes: Enable is set except in the bypass test near the end.
// Notes:   Ops reach the block through the datapath model.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int LANES = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic issue = 1'b0;
    logic gate_on = 1'b1;
    dp_exc_pkg::op_req_s req = '0;
    dp_exc_pkg::exc_flags_s [LANES-1:0] det = '0;
    logic op_valid;
    dp_exc_pkg::op_req_s op_req;
    dp_exc_pkg::exc_flags_s [LANES-1:0] lane_flags;
    logic exc_valid;
    dp_exc_pkg::exc_flags_s exc_flags;
    dp_exc_pkg::exc_flags_s exc_allowed;
    logic exc_stray;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    dp_simd_fp_exception_map #(.LANES(LANES)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
        .op_req(op_req), .lane_flags(lane_flags), .exc_valid(exc_valid),
        .exc_flags(exc_flags), .exc_allowed(exc_allowed),
        .exc_stray(exc_stray));

    fp_datapath_model #(.LANES(LANES)) far_end (
        .pclk(pclk), .presetn(presetn), .issue(issue), .req(req),
        .det(det), .op_valid(op_valid), .op_req(op_req),
        .lane_flags(lane_flags));

    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            complete_run;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        if (got !== exp)
            n_fail++;
    endtask

    // Holds the request until pready is seen high at a rising edge.
    task automatic rd_wr(input logic w, input logic [7:0] a,
                         input logic [31:0] d, input logic [31:0] x);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        if (!w)
            chk(prdata, x);
        chk({31'h0, pslverr}, {31'h0, a > 8'h14});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [5:0] rule_mask(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'hb: return 6'h3b;
            4'h2: return 6'h3f;
            4'h3, 4'h4, 4'h5, 4'hc: return 6'h03;
            4'h6: return 6'h23;
            4'h7, 4'h8: return 6'h21;
            4'h9: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction

    task automatic op(input logic [3:0] c, input logic pk,
                      input logic [11:0] d);
        logic [5:0] s;
        logic [5:0] g;
        s = pk ? d[11:6] | d[5:0] : d[5:0];
        g = gate_on ? rule_mask(c) : 6'h3f;
        @(posedge pclk);
        issue <= 1'b1;
        req <= dp_exc_pkg::op_req_s'({c, pk});
        det <= d;
        @(posedge pclk);
        issue <= 1'b0;
        @(posedge pclk);
        #1;
        chk({31'h0, exc_valid}, 32'h1);
        chk({26'h0, exc_allowed}, {26'h0, rule_mask(c)});
        chk({26'h0, exc_flags}, {26'h0, s & g});
        chk({31'h0, exc_stray}, {31'h0, gate_on && |(s & ~rule_mask(c))});
        @(posedge pclk);
        #1;
        chk({31'h0, exc_valid}, 32'h0);
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_wr(1'b0, 8'h00, 32'h0, 32'h0000_0001);
        rd_wr(1'b0, 8'h04, 32'h0, 32'h0000_0000);
        rd_wr(1'b0, 8'h0c, 32'h0, 32'h0000_0000);
        rd_wr(1'b0, 8'h10, 32'h0, 32'h0000_3b00);
        rd_wr(1'b0, 8'h18, 32'h0, 32'h0000_0000);
        rd_wr(1'b1, 8'h00, 32'h1, 32'h0);
        $display("test reset values done");
        op(4'h0, 1'b1, 12'hfff);
        op(4'h1, 1'b1, 12'hfff);
        op(4'h2, 1'b1, 12'hfff);
        op(4'h3, 1'b1, 12'hfff);
        op(4'h4, 1'b1, 12'hfff);
        op(4'h5, 1'b1, 12'hfff);
        op(4'h6, 1'b1, 12'hfff);
        op(4'h7, 1'b1, 12'hfff);
        op(4'h8, 1'b1, 12'hfff);
        op(4'h9, 1'b1, 12'hfff);
        op(4'ha, 1'b1, 12'hfff);
        op(4'hb, 1'b1, 12'hfff);
        op(4'hc, 1'b1, 12'hfff);
        op(4'hd, 1'b1, 12'hfff);
        op(4'he, 1'b1, 12'hfff);
        op(4'hf, 1'b1, 12'hfff);
        $display("test class masks done");
        op(4'h2, 1'b1, 12'h081);
        op(4'h2, 1'b0, 12'h081);
        op(4'h1, 1'b1, 12'h204);
        $display("test lane merge done");
        rd_wr(1'b0, 8'h0c, 32'h0, 32'h0000_000f);
        rd_wr(1'b0, 8'h08, 32'h0, 32'h0000_003f);
        rd_wr(1'b0, 8'h14, 32'h0, 32'h0000_003f);
        rd_wr(1'b0, 8'h04, 32'h0, 32'h8001_0108);
        rd_wr(1'b1, 8'h08, 32'h3f, 32'h0);
        rd_wr(1'b1, 8'h0c, 32'h0, 32'h0);
        rd_wr(1'b1, 8'h10, 32'h2, 32'h0);
        rd_wr(1'b0, 8'h08, 32'h0, 32'h0000_0000);
        rd_wr(1'b0, 8'h0c, 32'h0, 32'h0000_0000);
        rd_wr(1'b0, 8'h10, 32'h0, 32'h0000_3f02);
        $display("test registers done");
        rd_wr(1'b1, 8'h00, 32'h0, 32'h0);
        gate_on = 1'b0;
        rd_wr(1'b0, 8'h00, 32'h0, 32'h0000_0000);
        op(4'h1, 1'b1, 12'h204);
        rd_wr(1'b1, 8'h00, 32'h1, 32'h0);
        gate_on = 1'b1;
        op(4'h1, 1'b1, 12'h204);
        $display("test gate bypass done");
        complete_run;
    end
endmodule // tb
`default_nettype wire
